// ### common/switch_cfg_pkg.sv
// Package with the register map, field layout and timing constants of the switch config bank.
package switch_cfg_pkg;
    // Register indexes; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_PULSE_TIMING = 8'h1f;  // Activation time setting.
    localparam logic [7:0] IDX_PULSE_ENABLE = 8'h20;  // Per-input pulse current enable.
    localparam logic [7:0] IDX_THRESH       = 8'h21;  // Comparator threshold select.
    localparam logic [7:0] IDX_SWITCH_STATE = 8'h24;  // Registered comparator results.
    // Bus geometry.
    localparam int ADDR_W = 12;                        // Byte address width.
    localparam int DATA_W = 32;                        // Bus data width.
    localparam int NUM_IN = 24;                        // Switch inputs.
    localparam int GROUP  = 4;                         // Inputs sharing one threshold field.
    // Field layout.
    localparam int THR_W    = 12;                      // Writable threshold bits 11-0.
    localparam int TIME_LSB = 4;                       // Activation time field bits 6-4.
    localparam int TIME_W   = 3;                       // Width of the activation time field.
    // Values after reset.
    localparam logic [NUM_IN-1:0] ENABLE_RESET = 24'h000000;
    localparam logic [THR_W-1:0]  THRESH_RESET = 12'h000;
    localparam logic [TIME_W-1:0] TIME_RESET   = 3'h0;
    // One activation step is 64 us; the clock runs at 50 MHz.
    localparam int PULSE_STEP_US = 64;
    localparam int CLK_MHZ       = 50;
    localparam int STEP_CYCLES   = PULSE_STEP_US * CLK_MHZ;
    localparam int CNT_W         = 16;                 // Holds eight steps of cycles.
    // Pulse sequencer states.
    typedef enum logic [0:0] {PULSE_IDLE, PULSE_ACTIVE} pulse_state_t;
    // Registered bus answer.
    typedef struct packed {
        logic [DATA_W-1:0] rdata;                      // Read data.
        logic              ready;                      // Access phase completion.
        logic              slverr;                     // Unmapped address flag.
    } apb_resp_t;
endpackage : switch_cfg_pkg

// ### rtl/switch_threshold_config.sv
// Register bank for pulse current enables, pulse timing and comparator thresholds.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
// Operation
// - Enable bits 0-23 switch pulse current per input.
// - Threshold register at 21h, 12 bits, resets zero.
// - Codes 0-3 select 2, 2.7, 3, 4 V.
// - Bits 11-10 inputs 20-23, 9-8 inputs 16-19.
// - Bits 7-6 inputs 12-15, 5-4 inputs 8-11.
// - Bits 3-2 inputs 4-7, 1-0 inputs 0-3.
// - Threshold bits 23-12 read zero, ignore writes.
// - Pulse lasts 64 us per step, up to 512.
module switch_threshold_config
    import switch_cfg_pkg::*;
#(
    parameter int STEP_CYC = STEP_CYCLES               // Cycles in one 64 us step.
) (
    input  wire logic                  CLK,
    input  wire logic                  RSTN,
    input  wire logic                  CE,
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [ADDR_W-1:0]     PADDR,
    input  wire logic [DATA_W-1:0]     PWDATA,
    output logic      [DATA_W-1:0]     PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    input  wire logic                  PULSE_START,
    input  wire logic [NUM_IN-1:0]     COMP_RAW,
    output logic      [2*NUM_IN-1:0]   LEVEL_SELECT,
    output logic      [NUM_IN-1:0]     PULSE_CURRENT,
    output logic      [NUM_IN-1:0]     SWITCH_STATE
);
    // Software-visible registers.
    logic [NUM_IN-1:0]     pulse_current_input_enable;   // Per-input pulse enables.
    logic [THR_W-1:0]      comparator_threshold_select;  // Six 2-bit group codes.
    logic [TIME_W-1:0]     pulse_activation_time;        // Pulse length in 64 us steps.
    logic [NUM_IN-1:0]     next_enable;
    logic [THR_W-1:0]      next_thresh;
    logic [TIME_W-1:0]     next_time;
    // Bus answer registers.
    apb_resp_t             resp;
    apb_resp_t             next_resp;
    // Pulse sequencer state.
    pulse_state_t          state;
    pulse_state_t          next_state;
    logic [CNT_W-1:0]      cnt;
    logic [CNT_W-1:0]      next_cnt;
    logic [CNT_W-1:0]      limit;                        // Cycles in the selected pulse.
    // Comparator synchroniser and outputs.
    logic [NUM_IN-1:0]     sync1;
    logic [NUM_IN-1:0]     sync2;
    logic [NUM_IN-1:0]     sync3;
    logic [NUM_IN-1:0]     next_switch;
    logic [2*NUM_IN-1:0]   next_level;
    logic [NUM_IN-1:0]     next_pulse;
    // Decode helpers.
    logic [7:0]            idx;
    logic                  aligned;
    logic                  do_write;

    assign idx      = PADDR[9:2];
    assign aligned  = (PADDR[1:0] == 2'h0) && (PADDR[ADDR_W-1:10] == 2'h0);
    // A write lands only at the completing edge of the access phase.
    assign do_write = PSEL && PENABLE && PWRITE && resp.ready;
    assign limit    = CNT_W'((int'(pulse_activation_time) + 1) * STEP_CYC);

    // Computes next register contents from bus writes.
    always_comb begin
        next_enable = pulse_current_input_enable;
        next_thresh = comparator_threshold_select;
        next_time   = pulse_activation_time;
        if (do_write && aligned) begin
            // Each enable bit is read/write and drives its own input.
            if (idx == IDX_PULSE_ENABLE) begin
                next_enable = PWDATA[NUM_IN-1:0];
            end
            // Only bits 11-0 are stored; the reserved upper bits are dropped.
            if (idx == IDX_THRESH) begin
                next_thresh = PWDATA[THR_W-1:0];
            end
            // Activation time field sits in bits 6-4.
            if (idx == IDX_PULSE_TIMING) begin
                next_time = PWDATA[TIME_LSB +: TIME_W];
            end
        end
    end

    // Computes the bus answer during the setup cycle.
    always_comb begin
        next_resp        = '0;
        if (PSEL && !PENABLE) begin
            next_resp.ready = 1'b1;
            // Unaligned or unknown addresses answer with an error.
            if (!aligned) begin
                next_resp.slverr = 1'b1;
            end else if (idx == IDX_PULSE_ENABLE) begin
                next_resp.rdata = {8'h00, pulse_current_input_enable};
            end else if (idx == IDX_THRESH) begin
                next_resp.rdata = {20'h00000, comparator_threshold_select};
            end else if (idx == IDX_PULSE_TIMING) begin
                next_resp.rdata = {25'h0000000, pulse_activation_time, 4'h0};
            end else if (idx == IDX_SWITCH_STATE) begin
                next_resp.rdata = {8'h00, SWITCH_STATE};
            end else begin
                next_resp.slverr = 1'b1;
            end
        end
    end

    // Steps the pulse sequencer from a start tick through the selected time.
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            PULSE_IDLE: begin
                // A start tick opens a pulse window.
                if (PULSE_START) begin
                    next_state = PULSE_ACTIVE;
                    next_cnt   = '0;
                end
            end
            PULSE_ACTIVE: begin
                // The window closes after (code + 1) steps of 64 us.
                if (cnt == limit - CNT_W'(1)) begin
                    next_state = PULSE_IDLE;
                    next_cnt   = '0;
                end else begin
                    next_cnt = cnt + CNT_W'(1);
                end
            end
            default: begin
                next_state = PULSE_IDLE;
                next_cnt   = '0;
            end
        endcase
        // Current flows only on enabled inputs while the window is open.
        next_pulse = (next_state == PULSE_ACTIVE) ? pulse_current_input_enable : '0;
    end

    // Expands each group code onto its four inputs and qualifies comparator results.
    genvar g;
    generate
        for (g = 0; g < NUM_IN; g++) begin : g_input
            // Input g takes the code of group g/4: bits 2*(g/4)+1 and 2*(g/4).
            always_comb begin
                next_level[2*g +: 2] = comparator_threshold_select[2*(g/GROUP) +: 2];
                // A comparator change counts once the second and third stages agree.
                next_switch[g] = (sync2[g] == sync3[g]) ? sync3[g] : SWITCH_STATE[g];
            end
        end
    endgenerate

    // Registers all state; reset wins, then the clock enable freezes everything.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            pulse_current_input_enable  <= ENABLE_RESET;
            comparator_threshold_select <= THRESH_RESET;
            pulse_activation_time       <= TIME_RESET;
            resp                        <= '0;
            state                       <= PULSE_IDLE;
            cnt                         <= '0;
            sync1                       <= '0;
            sync2                       <= '0;
            sync3                       <= '0;
            SWITCH_STATE                <= '0;
            LEVEL_SELECT                <= '0;
            PULSE_CURRENT               <= '0;
        end else if (CE) begin
            pulse_current_input_enable  <= next_enable;
            comparator_threshold_select <= next_thresh;
            pulse_activation_time       <= next_time;
            resp                        <= next_resp;
            state                       <= next_state;
            cnt                         <= next_cnt;
            sync1                       <= COMP_RAW;
            sync2                       <= sync1;
            sync3                       <= sync2;
            SWITCH_STATE                <= next_switch;
            LEVEL_SELECT                <= next_level;
            PULSE_CURRENT               <= next_pulse;
        end
    end

    assign PRDATA  = resp.rdata;
    assign PREADY  = resp.ready;
    assign PSLVERR = resp.slverr;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // Sequences describing the two pulse sequencer steps.
    sequence pulse_start_s;
        CE && state == PULSE_IDLE && PULSE_START;
    endsequence
    sequence pulse_end_s;
        CE && state == PULSE_ACTIVE && cnt == limit - CNT_W'(1);
    endsequence

    // A write to the enable register lands on the next edge.
    enable_write_a: assert property (CE && do_write && aligned && idx == IDX_PULSE_ENABLE
        |=> pulse_current_input_enable == $past(PWDATA[NUM_IN-1:0]))
        else $error("Enable register did not take written data.");
    // A threshold write keeps only the low twelve bits.
    thresh_write_a: assert property (CE && do_write && aligned && idx == IDX_THRESH
        |=> comparator_threshold_select == $past(PWDATA[THR_W-1:0]))
        else $error("Threshold register did not take written data.");
    // Reserved threshold bits always read zero.
    reserved_zero_a: assert property (PSEL && PENABLE && PREADY && !PWRITE && aligned
        && idx == IDX_THRESH |-> PRDATA[DATA_W-1:THR_W] == 20'h00000)
        else $error("Reserved threshold bits read nonzero.");
    // Top group code reaches inputs 20 to 23.
    group_high_a: assert property (CE |=> LEVEL_SELECT[47:40]
        == {4{$past(comparator_threshold_select[11:10])}})
        else $error("Group five level select is wrong.");
    // Group three code reaches inputs 12 to 15.
    group_mid_a: assert property (CE |=> LEVEL_SELECT[31:24]
        == {4{$past(comparator_threshold_select[7:6])}})
        else $error("Group three level select is wrong.");
    // Group zero code reaches inputs 0 to 3.
    group_low_a: assert property (CE |=> LEVEL_SELECT[7:0]
        == {4{$past(comparator_threshold_select[1:0])}})
        else $error("Group zero level select is wrong.");
    // Codes pass unchanged so each selects its own level.
    level_code_a: assert property (CE |=> LEVEL_SELECT[17:16]
        == $past(comparator_threshold_select[5:4]))
        else $error("Level code altered on the way out.");
    // A start tick opens the window and lights enabled inputs.
    pulse_open_a: assert property (pulse_start_s |=> state == PULSE_ACTIVE
        && PULSE_CURRENT == $past(pulse_current_input_enable))
        else $error("Pulse window did not open.");
    // The window closes after exactly the selected count.
    pulse_close_a: assert property (pulse_end_s |=> state == PULSE_IDLE
        && PULSE_CURRENT == '0)
        else $error("Pulse window did not close on time.");
    // The counter never runs past the selected length.
    pulse_bound_a: assert property (state == PULSE_ACTIVE |-> cnt < limit)
        else $error("Pulse counter overran its limit.");
    // A settled comparator level is taken on the next edge.
    comp_take_a: assert property (CE && sync2[0] == sync3[0]
        |=> SWITCH_STATE[0] == $past(sync3[0]))
        else $error("Comparator result not registered.");
endmodule : switch_threshold_config

// ### testbench/tb_top.sv
// Self-checking bench for the switch threshold configuration bank.
`timescale 1ns/1ps
module tb_top;
    import switch_cfg_pkg::*;
    localparam int STEP = 4;                                  // Short activation step in cycles.
    localparam logic [ADDR_W-1:0] A_TIME = ADDR_W'({IDX_PULSE_TIMING, 2'b00}); // Timing word.
    localparam logic [ADDR_W-1:0] A_EN   = ADDR_W'({IDX_PULSE_ENABLE, 2'b00}); // Enable word.
    localparam logic [ADDR_W-1:0] A_THR  = ADDR_W'({IDX_THRESH, 2'b00});       // Threshold word.
    logic                clk = 1'b0;                          // Bench clock.
    logic                rstn, ce, psel, penable, pwrite, pulse_start; // Control inputs.
    logic [ADDR_W-1:0]   paddr;                               // Bus address.
    logic [DATA_W-1:0]   pwdata, prdata;                      // Bus data.
    logic                pready, pslverr;                     // Bus answer.
    logic [NUM_IN-1:0]   comp_raw, pulse_current, switch_state; // Per-input signals.
    logic [2*NUM_IN-1:0] level_select, exp_ls;                // Threshold codes per input.
    logic [DATA_W-1:0]   val;                                 // Value under test.
    logic [NUM_IN-1:0]   seen;                                // Pulse pattern observed.
    int                  err_total = 0;                       // Mismatches found.
    int                  tests_run = 0;                       // Comparisons made.
    int                  n;                                   // Cycle count of a pulse.
    // The clock toggles every half period of 10 ns.
    always #10 clk = ~clk;
    switch_threshold_config #(.STEP_CYC(STEP)) u_switch_threshold_config (
        .CLK(clk), .RSTN(rstn), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PULSE_START(pulse_start), .COMP_RAW(comp_raw), .LEVEL_SELECT(level_select),
        .PULSE_CURRENT(pulse_current), .SWITCH_STATE(switch_state));
    // Prints the counts and the verdict, then stops the run.
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [47:0] got, input logic [47:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    // One bus transfer: setup, then access held until ready is seen high.
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] r, output logic e);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        // Ready is sampled at each rising edge; the request stands until it is seen high.
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            err_total++;
            $display("unexpected at %0t: no bus answer", $time);
            tally_and_finish();
        end
        // The answer is taken and the request released at that same edge.
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Writes one register word.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] r;
        logic              e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    // Reads one register word and compares data and error flag.
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x, input logic xe);
        logic [DATA_W-1:0] r;
        logic              e;
        apb(1'b0, a, 32'h0, r, e);
        check({16'h0, r}, {16'h0, x}, "read data");
        check({47'h0, e}, {47'h0, xe}, "error flag");
    endtask : rd
    // Main sequence: reset, registers, pulse window, comparator path.
    initial begin
        rstn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; pulse_start = 1'b0; comp_raw = '0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rd(A_EN, 32'h0, 1'b0);
        rd(A_THR, 32'h0, 1'b0);
        check(level_select, 48'h0, "level select after reset");
        // Rotate the codes so every field meets every code once.
        for (int c = 0; c < 4; c++) begin
            val = 32'hfffff000;
            for (int g = 0; g < 6; g++) val[2*g+:2] = 2'((c + g) % 4);
            for (int i = 0; i < NUM_IN; i++) exp_ls[2*i+:2] = val[2*(i/GROUP)+:2];
            wr(A_THR, val);
            rd(A_THR, {20'h0, val[11:0]}, 1'b0);
            check(level_select, exp_ls, "level select");
        end
        rd(12'h3fc, 32'h0, 1'b1);
        rd(A_THR + 12'h1, 32'h0, 1'b1);
        wr(A_EN, 32'h000002a5);
        rd(A_EN, 32'h000002a5, 1'b0);
        // Shortest and longest activation times.
        for (int c = 0; c < 8; c += 7) begin
            wr(A_TIME, 32'(c) << TIME_LSB);
            rd(A_TIME, 32'(c) << TIME_LSB, 1'b0);
            pulse_start <= 1'b1;
            @(posedge clk);
            pulse_start <= 1'b0;
            n = 0;
            seen = '0;
            repeat (60) begin
                @(negedge clk);
                if (pulse_current !== '0) begin
                    n++;
                    seen = pulse_current;
                end
            end
            check(48'(n), 48'((c + 1) * STEP), "pulse length");
            check({24'h0, seen}, 48'h0002a5, "pulse inputs");
        end
        // Comparator levels pass through to the registered state.
        @(posedge clk);
        comp_raw <= 24'ha5c3e1;
        repeat (6) @(posedge clk);
        check({24'h0, switch_state}, 48'ha5c3e1, "switch state");
        comp_raw <= 24'h5a3c1e;
        repeat (6) @(posedge clk);
        check({24'h0, switch_state}, 48'h5a3c1e, "switch state");
        // With the clock enable low the comparator path holds its last result.
        ce <= 1'b0;
        comp_raw <= 24'h0f0f0f;
        repeat (6) @(posedge clk);
        check({24'h0, switch_state}, 48'h5a3c1e, "switch state frozen");
        ce <= 1'b1;
        repeat (6) @(posedge clk);
        check({24'h0, switch_state}, 48'h0f0f0f, "switch state resumed");
        rd(12'h090, 32'h000f0f0f, 1'b0);
        // A reset in mid-run clears the registers and the level selects again.
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(A_EN, 32'h0, 1'b0);
        rd(A_THR, 32'h0, 1'b0);
        check(level_select, 48'h0, "level select after second reset");
        tally_and_finish();
    end
endmodule : tb_top
